/* fds_pkg.sv */
package fds_pkg;
  // register addresses on the serial register port
  localparam logic [7:0] DIAG_CTRL_ADDR   = 8'h05;
  localparam logic [7:0] BLANK_CFG_ADDR   = 8'h06;
  localparam logic [7:0] SUPPLY_STAT_ADDR = 8'h07;
  localparam logic [7:0] THERM_STAT_ADDR  = 8'h08;
  localparam logic [7:0] SHORT_STAT_ADDR  = 8'h09;
  localparam logic [7:0] MISC_STAT_ADDR   = 8'h0a;
  localparam logic [7:0] SELF_TEST_ADDR   = 8'h0b;
  // diagnosis control fields
  localparam int RESTART_BIT   = 7;
  localparam int IND_CHECK_BIT = 6;
  localparam int FORCE_MSB     = 5;
  // status field positions
  localparam int UVB_BIT       = 7;
  localparam int OVC_BIT       = 5;
  localparam int OSC_OF_BIT    = 7;
  localparam int OSC_UF_BIT    = 6;
  localparam int PROH_MSB      = 5;
  localparam int SPI_ERR_BIT   = 2;
  localparam int GND_SHORT_MSB = 5;
  localparam int TEMP_MSB      = 5;
  localparam int ANA_TEST_CNT_LSB  = 4;
  localparam int ANA_TEST_PASS_BIT = 3;
  localparam int LOG_TEST_PASS_BIT = 2;
  localparam int ANA_TEST_END_BIT  = 1;
  localparam int LOG_TEST_END_BIT  = 0;
  // masks of implemented bits, everything else reads zero
  localparam logic [7:0] SUPPLY_MASK = 8'ha0;
  localparam logic [7:0] THERM_MASK  = 8'h38;
  localparam logic [7:0] SHORT_MASK  = 8'h3f;
  localparam logic [7:0] MISC_MASK   = 8'hfc;
  localparam logic [7:0] BLANK_MASK  = 8'h03;
  localparam logic [7:0] REG_RESET   = 8'h00;
  localparam logic [3:0] ANA_TEST_GOOD = 4'h8;
  // short response codes
  localparam logic [2:0] SH_HOLD_IND  = 3'h0;
  localparam logic [2:0] SH_PH_DET    = 3'h1;
  localparam logic [2:0] SH_PH_HOLD   = 3'h2;
  localparam logic [2:0] SH_ALL_DET   = 3'h3;
  localparam logic [2:0] SH_ALL_HOLD  = 3'h4;
  localparam logic [2:0] SH_CP_DET    = 3'h5;
  localparam logic [2:0] SH_CP_HOLD   = 3'h6;
  localparam logic [2:0] SH_DISABLE   = 3'h7;
  // blanking timing
  localparam int CLK_MHZ      = 200;
  localparam int BLANK_8_US   = 8;
  localparam int BLANK_16_US  = 16;
  localparam int BLANK_32_US  = 32;
  localparam int BLANK_8_CYC  = BLANK_8_US * CLK_MHZ;
  localparam int BLANK_16_CYC = BLANK_16_US * CLK_MHZ;
  localparam int BLANK_32_CYC = BLANK_32_US * CLK_MHZ;
  localparam logic [1:0] BLANK_ALWAYS = 2'h3;
endpackage : fds_pkg

/* fds_regs.sv */
// What this block does
// - writing one to restart bit requests self-test rerun; zero does nothing
// - restart honoured only when analog or logic self test failed
// - indicator-check bit forces fault indicator low
// - six force bits each force short detection per channel, indicator low
// - forced short acts like real one per short response select
// - clearing a force bit cancels its forced detect response; held responses drop only once all force bits are clear
// - response code 111 disables forced short diagnosis
// - blanking field: 8, 16, 32 us, or 11 limit always on
// - each gate output blanks current limit after every switching edge
// - supply status bit 7 undervoltage, bit 5 overvoltage
// - thermal status bits 5, 4, 3 for three temperature sensors
// - short status: ground shorts bits 5..3, supply shorts bits 2..0
// - misc status bit 7 over-frequency, bit 6 under-frequency
// - misc status bits 5..3 prohibited input on U, V, W
// - misc status bit 2 serial transfer failure
// - write one clears a flag once condition gone; zeros ignored
// - finish flags read one on completion, zero on abnormal stop
// - pass flags read one only when finished and passed
// - response field chooses indication, phase or all off, pump, held
// - both inputs high on a phase is prohibited; outputs forced low
`timescale 1ns/1ps
`default_nettype none
module fds_regs (
  input  wire logic       clock_i,
  input  wire logic       arst_n_i,
  input  wire logic       wr_en_i,
  input  wire logic       rd_en_i,
  input  wire logic [7:0] addr_i,
  input  wire logic [7:0] wdata_i,
  output logic      [7:0] rdata_o,
  input  wire logic       uvb_det_i,
  input  wire logic       ovc_det_i,
  input  wire logic [2:0] overtemp_det_i,
  input  wire logic [5:0] short_det_i,
  input  wire logic       osc_over_i,
  input  wire logic       osc_under_i,
  input  wire logic       spi_err_i,
  input  wire logic [5:0] gate_in_i,
  input  wire logic [3:0] analog_self_test_cnt_i,
  input  wire logic       analog_self_test_end_i,
  input  wire logic       logic_self_test_end_i,
  input  wire logic       analog_self_test_pass_i,
  input  wire logic       logic_self_test_pass_i,
  input  wire logic [2:0] short_response_select_i,
  output logic            fault_indicator_pin_n_o,
  output logic      [5:0] gate_out_o,
  output logic      [5:0] limit_en_o,
  output logic            charge_pump_off_o,
  output logic            self_test_restart_o
);
  import fds_pkg::*;

  logic [7:0]  diag_reg;
  logic [1:0]  blank_reg;
  logic [7:0]  supply_reg, therm_reg, short_reg, misc_reg;
  logic [22:0] sync1_reg, sync2_reg;
  logic [5:0]  drv_hold_reg;
  logic        cp_hold_reg;
  logic [5:0]  force_sh;
  logic [5:0]  short_all;
  logic [2:0]  prohibit;
  logic        bist_failed;

  // all detector and gate inputs come from other domains: two flops first
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= {uvb_det_i, ovc_det_i, overtemp_det_i, short_det_i, osc_over_i,
                    osc_under_i, spi_err_i, gate_in_i, short_response_select_i};
      sync2_reg <= sync1_reg;
    end
  end

  logic       uvb_s, ovc_s, of_s, uf_s, spi_s;
  logic [2:0] temp_s, sel_s;
  logic [5:0] short_s, gate_s;
  assign {uvb_s, ovc_s, temp_s, short_s, of_s, uf_s, spi_s, gate_s, sel_s} = sync2_reg;

  logic wr_diag, wr_blank, wr_sup, wr_th, wr_sh, wr_misc;
  assign wr_diag  = wr_en_i && addr_i == DIAG_CTRL_ADDR;
  assign wr_blank = wr_en_i && addr_i == BLANK_CFG_ADDR;
  assign wr_sup   = wr_en_i && addr_i == SUPPLY_STAT_ADDR;
  assign wr_th    = wr_en_i && addr_i == THERM_STAT_ADDR;
  assign wr_sh    = wr_en_i && addr_i == SHORT_STAT_ADDR;
  assign wr_misc  = wr_en_i && addr_i == MISC_STAT_ADDR;

  assign bist_failed = !(analog_self_test_end_i && analog_self_test_pass_i
                         && logic_self_test_end_i && logic_self_test_pass_i);

  // restart bit is a request: it reads back as written but only pulses when allowed
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      diag_reg            <= REG_RESET;
      self_test_restart_o <= 1'b0;
    end else begin
      self_test_restart_o <= 1'b0;
      if (wr_diag) begin
        diag_reg <= wdata_i;
        if (wdata_i[RESTART_BIT] && bist_failed)
          self_test_restart_o <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      blank_reg <= 2'h0;
    end else if (wr_blank) begin
      blank_reg <= wdata_i[1:0];
    end
  end

  // force bits map: [5] U ground-side ... [0] W supply-side, same order as short flags
  assign force_sh  = (sel_s == SH_DISABLE) ? 6'h00 : diag_reg[FORCE_MSB:0];
  assign short_all = (sel_s == SH_DISABLE) ? 6'h00 : (short_s | force_sh);

  // set wins over a simultaneous clear so no event is lost
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      supply_reg <= REG_RESET;
      therm_reg  <= REG_RESET;
      short_reg  <= REG_RESET;
      misc_reg   <= REG_RESET;
    end else begin
      supply_reg <= ((supply_reg & ~(wr_sup ? wdata_i : 8'h00))
                     | {uvb_s, 1'b0, ovc_s, 5'h00}) & SUPPLY_MASK;
      therm_reg  <= ((therm_reg & ~(wr_th ? wdata_i : 8'h00))
                     | {2'h0, temp_s, 3'h0}) & THERM_MASK;
      short_reg  <= ((short_reg & ~(wr_sh ? wdata_i : 8'h00))
                     | {2'h0, short_all}) & SHORT_MASK;
      misc_reg   <= ((misc_reg & ~(wr_misc ? wdata_i : 8'h00))
                     | {of_s, uf_s, prohibit, spi_s, 2'h0}) & MISC_MASK;
    end
  end

  // gate inputs ordered {u_hi, u_lo, v_hi, v_lo, w_hi, w_lo}
  genvar p;
  generate
    for (p = 0; p < 3; p++) begin : g_prohibit
      assign prohibit[2-p] = gate_s[5-2*p] && gate_s[4-2*p];
    end
  endgenerate

  // per-phase short: either flag of the phase pair
  logic [2:0] ph_short;
  logic       any_short;
  assign ph_short[2] = short_all[5] | short_all[2];
  assign ph_short[1] = short_all[4] | short_all[1];
  assign ph_short[0] = short_all[3] | short_all[0];
  assign any_short   = |short_all;

  // clearing every force bit drops held responses; a real short still present
  // re-arms the hold a cycle later, one already gone loses its hold
  logic hold_release;
  assign hold_release = (short_reg == 8'h00 && !any_short)
                        || (wr_diag && wdata_i[FORCE_MSB:0] == 6'h00
                            && diag_reg[FORCE_MSB:0] != 6'h00);

  // held responses stay until every short flag is cleared and no short remains, or until a write clears every set force bit
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      drv_hold_reg <= 6'h00;
      cp_hold_reg  <= 1'b0;
    end else begin
      drv_hold_reg <= hold_release ? 6'h00 :
                      drv_hold_reg | (
                        (sel_s == SH_PH_HOLD) ? {{2{ph_short[2]}}, {2{ph_short[1]}},
                                                 {2{ph_short[0]}}} :
                        (sel_s == SH_ALL_HOLD || sel_s == SH_CP_HOLD) ? {6{any_short}} :
                        6'h00);
      cp_hold_reg  <= hold_release ? 1'b0 :
                      cp_hold_reg | (sel_s == SH_CP_HOLD && any_short);
    end
  end

  logic [5:0] drv_off;
  always_comb begin
    drv_off = drv_hold_reg;
    unique case (sel_s)
      SH_PH_DET: drv_off = drv_off | {{2{ph_short[2]}}, {2{ph_short[1]}}, {2{ph_short[0]}}};
      SH_ALL_DET, SH_CP_DET: drv_off = drv_off | {6{any_short}};
      SH_HOLD_IND, SH_PH_HOLD, SH_ALL_HOLD, SH_CP_HOLD, SH_DISABLE: drv_off = drv_off;
    endcase
  end

  logic [5:0] proh_off;
  assign proh_off = {{2{prohibit[2]}}, {2{prohibit[1]}}, {2{prohibit[0]}}};

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      gate_out_o              <= 6'h00;
      charge_pump_off_o       <= 1'b0;
      fault_indicator_pin_n_o <= 1'b1;
    end else begin
      gate_out_o        <= gate_s & ~drv_off & ~proh_off;
      charge_pump_off_o <= cp_hold_reg || (sel_s == SH_CP_DET && any_short);
      fault_indicator_pin_n_o <= !(diag_reg[IND_CHECK_BIT] || (|force_sh)
                                   || (|supply_reg) || (|therm_reg)
                                   || (|short_reg) || (|misc_reg));
    end
  end

  // blanking counters: one per gate output, restarted on every edge
  logic [15:0] blank_len;
  always_comb begin
    unique case (blank_reg)
      2'h0: blank_len = 16'(BLANK_8_CYC);
      2'h1: blank_len = 16'(BLANK_16_CYC);
      2'h2: blank_len = 16'(BLANK_32_CYC);
      2'h3: blank_len = 16'h0000;
    endcase
  end

  generate
    for (p = 0; p < 6; p++) begin : g_blank
      logic [15:0] cnt_reg;
      logic        gate_q_reg;
      always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
          cnt_reg    <= 16'h0000;
          gate_q_reg <= 1'b0;
        end else begin
          gate_q_reg <= gate_out_o[p];
          // a switch to always-on must not let a running blank finish first
          if (blank_reg == BLANK_ALWAYS)
            cnt_reg <= 16'h0000;
          else if (gate_q_reg != gate_out_o[p])
            cnt_reg <= blank_len;
          else if (cnt_reg != 16'h0000)
            cnt_reg <= cnt_reg - 16'h0001;
        end
      end
      assign limit_en_o[p] = (cnt_reg == 16'h0000);
    end
  endgenerate

  // read data registered one cycle after rd_en_i
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_o <= 8'h00;
    end else if (rd_en_i) begin
      unique case (addr_i)
        DIAG_CTRL_ADDR:   rdata_o <= diag_reg;
        BLANK_CFG_ADDR:   rdata_o <= {6'h00, blank_reg};
        SUPPLY_STAT_ADDR: rdata_o <= supply_reg;
        THERM_STAT_ADDR:  rdata_o <= therm_reg;
        SHORT_STAT_ADDR:  rdata_o <= short_reg;
        MISC_STAT_ADDR:   rdata_o <= misc_reg;
        SELF_TEST_ADDR:   rdata_o <= {analog_self_test_cnt_i,
                                      analog_self_test_end_i && analog_self_test_pass_i,
                                      logic_self_test_end_i && logic_self_test_pass_i,
                                      analog_self_test_end_i, logic_self_test_end_i};
        default:          rdata_o <= 8'h00;
      endcase
    end
  end
endmodule : fds_regs
`default_nettype wire

/* fds_regs_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module fds_regs_sva
  import fds_pkg::*;
(
  input wire logic       clock_i,
  input wire logic       arst_n_i,
  input wire logic       wr_en_i,
  input wire logic       rd_en_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic [7:0] rdata_o,
  input wire logic [3:0] analog_self_test_cnt_i,
  input wire logic       analog_self_test_end_i,
  input wire logic       logic_self_test_end_i,
  input wire logic       analog_self_test_pass_i,
  input wire logic       logic_self_test_pass_i,
  input wire logic       fault_indicator_pin_n_o,
  input wire logic [5:0] gate_out_o,
  input wire logic [5:0] limit_en_o,
  input wire logic       self_test_restart_o
);
  logic [1:0] blank_reg;
  // shadow of the blanking field, kept from the write strobes alone
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) blank_reg <= 2'h0;
    else if (wr_en_i && addr_i == BLANK_CFG_ADDR) blank_reg <= wdata_i[1:0];
  end
  default clocking @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);
  a_restart_one_cycle: assert property (
    self_test_restart_o |=> !self_test_restart_o) else $error("restart pulse too long");
  a_restart_cause: assert property (
    self_test_restart_o |-> $past(wr_en_i && addr_i == DIAG_CTRL_ADDR && wdata_i[RESTART_BIT]))
    else $error("restart without request");
  a_restart_gated: assert property (
    self_test_restart_o |-> !$past(analog_self_test_end_i && analog_self_test_pass_i
    && logic_self_test_end_i && logic_self_test_pass_i))
    else $error("restart while self tests passed");
  a_unmapped_zero: assert property (
    rd_en_i && (addr_i < DIAG_CTRL_ADDR || addr_i > SELF_TEST_ADDR) |=> rdata_o == 8'h00)
    else $error("unmapped read not zero");
  a_self_test_read: assert property (
    rd_en_i && addr_i == SELF_TEST_ADDR |=> rdata_o == $past({analog_self_test_cnt_i,
    analog_self_test_pass_i & analog_self_test_end_i,
    logic_self_test_pass_i & logic_self_test_end_i,
    analog_self_test_end_i, logic_self_test_end_i}))
    else $error("self test result read wrong");
  a_ind_check: assert property (
    wr_en_i && addr_i == DIAG_CTRL_ADDR && wdata_i[IND_CHECK_BIT]
    |-> ##[1:2] !fault_indicator_pin_n_o) else $error("indicator not forced low");
  a_prohibit_pair: assert property (
    !((gate_out_o[5] && gate_out_o[4]) || (gate_out_o[3] && gate_out_o[2])
    || (gate_out_o[1] && gate_out_o[0]))) else $error("both gates of a phase on");
  a_blank_always: assert property (
    blank_reg == BLANK_ALWAYS && $past(blank_reg) == BLANK_ALWAYS |-> &limit_en_o)
    else $error("current limit off with always setting");
endmodule : fds_regs_sva
bind fds_regs fds_regs_sva chk (.clock_i, .arst_n_i, .wr_en_i, .rd_en_i, .addr_i, .wdata_i,
  .rdata_o, .analog_self_test_cnt_i, .analog_self_test_end_i, .logic_self_test_end_i,
  .analog_self_test_pass_i, .logic_self_test_pass_i,
  .fault_indicator_pin_n_o, .gate_out_o, .limit_en_o, .self_test_restart_o);
`default_nettype wire

/* fds_host.sv */
`timescale 1ns/1ps
`default_nettype none
module fds_host (
  input  wire logic       clock_i,
  input  wire logic [7:0] rdata_i,
  output logic            wr_en_o,
  output logic            rd_en_o,
  output logic      [7:0] addr_o,
  output logic      [7:0] wdata_o
);
  initial begin
    wr_en_o = 1'b0;
    rd_en_o = 1'b0;
    addr_o  = 8'h00;
    wdata_o = 8'h00;
  end
  // released lines carry the inverse, so a stale value is never taken for a hold
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock_i);
    {wr_en_o, addr_o, wdata_o} = {1'b1, a, d};
    @(negedge clock_i);
    {wr_en_o, addr_o, wdata_o} = {1'b0, ~a, ~d};
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clock_i);
    {rd_en_o, addr_o} = {1'b1, a};
    @(negedge clock_i);
    {rd_en_o, addr_o} = {1'b0, ~a};
    d = rdata_i;
  endtask : rd
endmodule : fds_host
`default_nettype wire

/* tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import fds_pkg::*;
  logic       clock_i, arst_n_i, wr_en_i, rd_en_i, uvb_det_i, ovc_det_i, osc_over_i;
  logic       osc_under_i, spi_err_i, analog_self_test_end_i, logic_self_test_end_i;
  logic       analog_self_test_pass_i, logic_self_test_pass_i;
  logic       fault_indicator_pin_n_o, charge_pump_off_o, self_test_restart_o, seen;
  logic [7:0] addr_i, wdata_i, rdata_o, d;
  logic [5:0] short_det_i, gate_in_i, gate_out_o, limit_en_o;
  logic [3:0] analog_self_test_cnt_i;
  logic [2:0] overtemp_det_i, short_response_select_i;
  int         n_errors, n_checks, cyc;
  logic [7:0] sa [4] = '{8'h07, 8'h08, 8'h09, 8'h0a};
  logic [7:0] sm [4] = '{8'ha0, 8'h38, 8'h3f, 8'hfc};
  fds_regs uut (.clock_i, .arst_n_i, .wr_en_i, .rd_en_i, .addr_i, .wdata_i, .rdata_o,
    .uvb_det_i, .ovc_det_i, .overtemp_det_i, .short_det_i, .osc_over_i, .osc_under_i,
    .spi_err_i, .gate_in_i, .analog_self_test_cnt_i, .analog_self_test_end_i,
    .logic_self_test_end_i, .analog_self_test_pass_i, .logic_self_test_pass_i,
    .short_response_select_i, .fault_indicator_pin_n_o, .gate_out_o,
    .limit_en_o, .charge_pump_off_o, .self_test_restart_o);
  fds_host host (.clock_i, .rdata_i(rdata_o), .wr_en_o(wr_en_i), .rd_en_o(rd_en_i),
    .addr_o(addr_i), .wdata_o(wdata_i));
  initial begin
    clock_i = 1'b0;
    forever #2.5 clock_i = ~clock_i;
  end
  task automatic stop_test();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : stop_test
  always @(posedge clock_i) begin
    cyc++;
    if (self_test_restart_o === 1'b1) seen = 1'b1;
    if (cyc == 60000) begin
      n_errors++;
      stop_test();
    end
  end
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    host.rd(a, d);
    chk("rdata", {8'h00, e}, {8'h00, d});
  endtask : rchk
  task automatic idle(input int n);
    repeat (n) @(negedge clock_i);
  endtask : idle
  // count blanked cycles after one edge of the w low-side gate
  task automatic blank(input logic [1:0] f, input int c);
    int n;
    n = 0;
    host.wr(BLANK_CFG_ADDR, {6'h00, f});
    gate_in_i[0] = ~gate_in_i[0];
    repeat (7000) begin
      @(negedge clock_i);
      n += (limit_en_o[0] === 1'b0);
    end
    chk("blank", 16'h1, {15'h0, n >= c && n <= c + 2});
  endtask : blank
  initial begin
    {arst_n_i, uvb_det_i, ovc_det_i, osc_over_i, osc_under_i, spi_err_i, seen} = '0;
    {overtemp_det_i, short_det_i, gate_in_i, short_response_select_i} = '0;
    {analog_self_test_cnt_i, analog_self_test_end_i, logic_self_test_end_i} = 6'h23;
    {analog_self_test_pass_i, logic_self_test_pass_i} = 2'h3;
    repeat (4) @(posedge clock_i);
    @(negedge clock_i) arst_n_i = 1'b1;
    for (int a = 5; a < 11; a++) rchk(a[7:0], 8'h00);
    rchk(8'h0c, 8'h00);
    host.wr(BLANK_CFG_ADDR, 8'hff);
    rchk(BLANK_CFG_ADDR, 8'h03);
    host.wr(SELF_TEST_ADDR, 8'h00);
    rchk(SELF_TEST_ADDR, 8'h8f);
    host.wr(DIAG_CTRL_ADDR, 8'h80);
    idle(2);
    chk("restart", 16'h0, {15'h0, seen});
    logic_self_test_pass_i = 1'b0;
    host.wr(DIAG_CTRL_ADDR, 8'h80);
    idle(2);
    chk("restart", 16'h1, {15'h0, seen});
    seen = 1'b0;
    host.wr(DIAG_CTRL_ADDR, 8'h00);
    idle(2);
    chk("restart", 16'h0, {15'h0, seen});
    rchk(SELF_TEST_ADDR, 8'h8b);
    analog_self_test_end_i = 1'b0;
    rchk(SELF_TEST_ADDR, 8'h81);
    host.wr(DIAG_CTRL_ADDR, 8'h40);
    idle(2);
    chk("indicator", 16'h0, {15'h0, fault_indicator_pin_n_o});
    host.wr(DIAG_CTRL_ADDR, 8'h00);
    idle(2);
    chk("indicator", 16'h1, {15'h0, fault_indicator_pin_n_o});
    gate_in_i = 6'h24;
    idle(6);
    chk("gates", 16'h24, {10'h0, gate_out_o});
    {uvb_det_i, ovc_det_i, overtemp_det_i, short_det_i} = '1;
    {osc_over_i, osc_under_i, spi_err_i, gate_in_i} = '1;
    idle(6);
    chk("gates", 16'h0, {10'h0, gate_out_o});
    {uvb_det_i, ovc_det_i, overtemp_det_i, short_det_i, osc_over_i, osc_under_i} = '0;
    {spi_err_i, gate_in_i} = {1'b0, 6'h24};
    idle(6);
    for (int i = 0; i < 4; i++) rchk(sa[i], sm[i]);
    chk("indicator", 16'h0, {15'h0, fault_indicator_pin_n_o});
    for (int i = 0; i < 4; i++) begin
      host.wr(sa[i], 8'h00);
      rchk(sa[i], sm[i]);
      host.wr(sa[i], sm[i]);
      rchk(sa[i], 8'h00);
    end
    uvb_det_i = 1'b1;
    idle(6);
    host.wr(SUPPLY_STAT_ADDR, 8'h80);
    rchk(SUPPLY_STAT_ADDR, 8'h80);
    uvb_det_i = 1'b0;
    idle(6);
    host.wr(SUPPLY_STAT_ADDR, 8'h80);
    rchk(SUPPLY_STAT_ADDR, 8'h00);
    idle(2);
    chk("indicator", 16'h1, {15'h0, fault_indicator_pin_n_o});
    short_response_select_i = SH_ALL_DET;
    idle(4);
    host.wr(DIAG_CTRL_ADDR, 8'h20);
    idle(4);
    chk("gates", 16'h0, {10'h0, gate_out_o});
    chk("indicator", 16'h0, {15'h0, fault_indicator_pin_n_o});
    host.wr(DIAG_CTRL_ADDR, 8'h00);
    idle(4);
    chk("gates", 16'h24, {10'h0, gate_out_o});
    host.wr(SHORT_STAT_ADDR, 8'h3f);
    idle(6);
    chk("gates", 16'h24, {10'h0, gate_out_o});
    short_response_select_i = SH_CP_DET;
    idle(4);
    host.wr(DIAG_CTRL_ADDR, 8'h01);
    idle(4);
    chk("pump", 16'h1, {15'h0, charge_pump_off_o});
    host.wr(DIAG_CTRL_ADDR, 8'h00);
    idle(4);
    chk("pump", 16'h0, {15'h0, charge_pump_off_o});
    host.wr(SHORT_STAT_ADDR, 8'h3f);
    idle(6);
    chk("pump", 16'h0, {15'h0, charge_pump_off_o});
    short_response_select_i = SH_PH_HOLD;
    idle(4);
    host.wr(DIAG_CTRL_ADDR, 8'h20);
    idle(4);
    chk("gates", 16'h04, {10'h0, gate_out_o});
    host.wr(DIAG_CTRL_ADDR, 8'h00);
    idle(4);
    chk("gates", 16'h24, {10'h0, gate_out_o});
    host.wr(SHORT_STAT_ADDR, 8'h3f);
    idle(6);
    short_response_select_i = SH_DISABLE;
    idle(4);
    host.wr(DIAG_CTRL_ADDR, 8'h3f);
    idle(4);
    chk("gates", 16'h24, {10'h0, gate_out_o});
    chk("indicator", 16'h1, {15'h0, fault_indicator_pin_n_o});
    host.wr(DIAG_CTRL_ADDR, 8'h00);
    blank(2'h0, BLANK_8_CYC);
    blank(2'h1, BLANK_16_CYC);
    blank(2'h2, BLANK_32_CYC);
    blank(BLANK_ALWAYS, 0);
    stop_test();
  end
endmodule : tb_top
`default_nettype wire
